// File: design/ssg_pkg.sv
// package for the security supervisor: register map, field layout, timing
// assumes a single 20 MHz core clock and a simple strobe register port
package ssg_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam int NUM_DET = 7;
	// register byte addresses
	localparam logic [7:0] REG_EVENT = 8'h00;
	localparam logic [7:0] REG_CTRL = 8'h04;
	localparam logic [7:0] REG_MASK = 8'h08;
	localparam logic [7:0] REG_FAULT = 8'h0C;
	localparam logic [7:0] REG_RGN0 = 8'h10;
	localparam logic [7:0] REG_RGN1 = 8'h14;
	localparam logic [7:0] REG_ACCESS = 8'h18;
	localparam logic [7:0] REG_MODE = 8'h1C;
	localparam logic [7:0] REG_TRACE = 8'h20;
	localparam logic [7:0] REG_UNLOCK = 8'h24;
	// ctrl fields
	localparam int CTRL_RST_BIT = 0;
	localparam int CTRL_WEN_BIT = 1;
	// fault status bits
	localparam int FLT_INVALID = 0;
	localparam int FLT_REGION = 1;
	localparam int FLT_EXEC = 2;
	localparam int FLT_DET = 3;
	localparam int FLT_W = 4;
	// access control fields: per region {user_write, user_read, user_exec}
	localparam int ACC_R0_EXEC = 0;
	localparam int ACC_R0_READ = 1;
	localparam int ACC_R0_WRITE = 2;
	localparam int ACC_R1_EXEC = 3;
	localparam int ACC_R1_READ = 4;
	localparam int ACC_R1_WRITE = 5;
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [15:0] ACCESS_RESET = 16'h0000;
	localparam logic [15:0] ZERO16 = 16'h0000;
	localparam logic [7:0] REGION_MAX = 8'h3F;
	localparam logic [15:0] TEST_PASSWORD = 16'hA5C3;
	localparam logic [15:0] NORMAL_KEY = 16'h5AF0;
	// time for software to enable security writes
	localparam int WEN_WINDOW_CYC = 128;
	localparam logic [7:0] WEN_LAST = 8'(WEN_WINDOW_CYC - 1);
	localparam int FILT_LEN = 3;
	typedef enum logic [1:0] {
		SSG_MODE_TEST_LOCKED = 2'b00,
		SSG_MODE_TEST_OPEN = 2'b01,
		SSG_MODE_NORMAL = 2'b10
	} ssg_mode_type;
endpackage

// File: design/ssg_pad_filter.sv
// glitch filter for one external pad (reset or clock pad)
// input is asynchronous; three flops then a run-length agreement stage
`timescale 1ns/1ps
`default_nettype none
module ssg_pad_filter
	import ssg_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic clk_en_in,
	input wire logic pad_in,
	output logic level_out
);
	import ssg_pkg::*;
	logic [2:0] sync_q;
	logic [FILT_LEN-1:0] hist_q;
	logic level_q;
	wire logic agree = (sync_q[1] == sync_q[2]);
	wire logic all_hi = agree && (&hist_q);
	wire logic all_lo = agree && ~(|hist_q);
	always_ff @(posedge core_clk_in)
	begin
		if (!rst_n_in)
		begin
			sync_q <= 3'b000;
			hist_q <= '0;
			level_q <= 1'b0;
		end
		else if (clk_en_in)
		begin
			sync_q <= {sync_q[1:0], pad_in};
			// a pulse shorter than the history length never reaches the core
			if (agree)
				hist_q <= {hist_q[FILT_LEN-2:0], sync_q[2]};
			if (all_hi)
				level_q <= 1'b1;
			else if (all_lo)
				level_q <= 1'b0;
		end
	end
	assign level_out = level_q;
endmodule
`default_nettype wire

// File: design/ssg_access_check.sv
// combinational access checker for the region protection unit
// assumes bus address, kind and privilege are from the core clock domain
`timescale 1ns/1ps
`default_nettype none
module ssg_access_check
	import ssg_pkg::*;
(
	input wire logic acc_valid_in,
	input wire logic [15:0] acc_addr_in,
	input wire logic acc_write_in,
	input wire logic acc_fetch_in,
	input wire logic acc_eeprom_in,
	input wire logic acc_priv_in,
	input wire logic [15:0] rgn0_top_in,
	input wire logic [15:0] rgn1_top_in,
	input wire logic [15:0] rights_in,
	input wire logic [15:0] mapped_top_in,
	output logic invalid_out,
	output logic region_out,
	output logic exec_out
);
	import ssg_pkg::*;
	wire logic in_r0 = acc_addr_in <= rgn0_top_in;
	wire logic in_r1 = !in_r0 && (acc_addr_in <= rgn1_top_in);
	wire logic unmapped = acc_addr_in > mapped_top_in;
	wire logic r_ok = in_r0 ? rights_in[ACC_R0_READ] : rights_in[ACC_R1_READ];
	wire logic w_ok = in_r0 ? rights_in[ACC_R0_WRITE] : rights_in[ACC_R1_WRITE];
	wire logic x_ok = in_r0 ? rights_in[ACC_R0_EXEC] : rights_in[ACC_R1_EXEC];
	wire logic in_rgn = in_r0 || in_r1;
	// privilege selects checking
	// privileged mode bypasses region rights; user mode is checked
	wire logic user = !acc_priv_in;
	assign invalid_out = acc_valid_in && unmapped;
	assign region_out = acc_valid_in && !unmapped && user && in_rgn && !acc_fetch_in
		&& (acc_write_in ? !w_ok : !r_ok);
	assign exec_out = acc_valid_in && !unmapped && user && acc_fetch_in
		&& (acc_eeprom_in || in_rgn) && !x_ok;
endmodule
`default_nettype wire

// File: design/ssg_supervisor.sv
// security supervisor: detector events, pad filters, register write lock,
// region protection faults, one-way test to normal switch
// assumes detectors and pads are asynchronous; bus signals are on core_clk_in
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - each detector event is latched into a readable event register
// - reset reaction selected: any detector event requests chip reset on the cycle after detection
// - flag reaction selected: event only sets a status bit, no reset
// - seven detector inputs: frequency, voltage, temperature, light, insulation, shield, glitch
// - reset and clock pads are glitch filtered before internal use
// - software cannot disable detectors or filters, only choose reaction
// - security write enable must be set within 128 cycles or writes lock
// - access to an invalid address raises the fast fault interrupt
// - region protection unit and access control register give per-region rights
// - a region rights violation raises non-maskable fast fault interrupt
// - disallowed instruction fetch from eeprom raises fast fault interrupt
// - access decisions depend on privileged or user mode
// - every register loads its default value on reset
// - test mode may be left once for normal mode, never re-entered
// - test mode opens only after the correct password
// - traceability data become read-only after normal mode entry
// - normal mode has privileged and user sub-modes, checked separately
module ssg_supervisor
	import ssg_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic clk_en_in,
	input wire logic [ADDR_W-1:0] reg_addr_in,
	input wire logic [DATA_W-1:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [DATA_W-1:0] reg_rdata_out,
	input wire logic det_freq_in,
	input wire logic det_volt_in,
	input wire logic det_temp_in,
	input wire logic det_light_in,
	input wire logic det_insul_in,
	input wire logic det_shield_in,
	input wire logic det_glitch_in,
	input wire logic pad_rst_in,
	input wire logic pad_clk_in,
	output logic pad_rst_out,
	output logic pad_clk_out,
	input wire logic acc_valid_in,
	input wire logic [15:0] acc_addr_in,
	input wire logic acc_write_in,
	input wire logic acc_fetch_in,
	input wire logic acc_eeprom_in,
	input wire logic acc_priv_in,
	input wire logic nv_normal_in,
	output logic nv_normal_set_out,
	output logic chip_reset_out,
	output logic fast_fault_interrupt_out,
	output logic irq_out,
	output logic test_mode_out
);
	import ssg_pkg::*;

	logic [NUM_DET-1:0] det_raw;
	logic [NUM_DET-1:0] s1_q, s2_q, s3_q;
	logic [NUM_DET-1:0] event_q, event_d;
	logic [NUM_DET-1:0] mask_q;
	logic [FLT_W-1:0] fault_q, fault_d;
	logic [15:0] ctrl_q, rgn0_q, rgn1_q, access_q, trace_q;
	logic [7:0] wcnt_q;
	logic locked_q;
	logic wen_q;
	logic reset_q;
	logic [DATA_W-1:0] rdata_q;
	logic nv_set_q;
	ssg_mode_type mode_q;
	logic inv_f, rgn_f, exe_f;

	assign det_raw = {det_glitch_in, det_shield_in, det_insul_in, det_light_in,
		det_temp_in, det_volt_in, det_freq_in};

	genvar gi;
	generate
		for (gi = 0; gi < NUM_DET; gi++)
		begin : g_det
			always_ff @(posedge core_clk_in)
			begin
				if (!rst_n_in)
				begin
					s1_q[gi] <= 1'b0;
					s2_q[gi] <= 1'b0;
					s3_q[gi] <= 1'b0;
				end
				else if (clk_en_in)
				begin
					s1_q[gi] <= det_raw[gi];
					s2_q[gi] <= s1_q[gi];
					s3_q[gi] <= s2_q[gi];
				end
			end
		end
	endgenerate
	// a detection counts once the last two stages agree high
	wire logic [NUM_DET-1:0] det_hit = s2_q & s3_q;
	wire logic any_det = |det_hit;

	// pad filters, no enable bit exists so software cannot bypass them
	ssg_pad_filter u_rst_filt (
		.core_clk_in(core_clk_in),
		.rst_n_in(rst_n_in),
		.clk_en_in(clk_en_in),
		.pad_in(pad_rst_in),
		.level_out(pad_rst_out)
	);
	ssg_pad_filter u_clk_filt (
		.core_clk_in(core_clk_in),
		.rst_n_in(rst_n_in),
		.clk_en_in(clk_en_in),
		.pad_in(pad_clk_in),
		.level_out(pad_clk_out)
	);

	ssg_access_check u_chk (
		.acc_valid_in(acc_valid_in),
		.acc_addr_in(acc_addr_in),
		.acc_write_in(acc_write_in),
		.acc_fetch_in(acc_fetch_in),
		.acc_eeprom_in(acc_eeprom_in),
		.acc_priv_in(acc_priv_in),
		.rgn0_top_in(rgn0_q),
		.rgn1_top_in(rgn1_q),
		.rights_in(access_q),
		.mapped_top_in({8'h00, REGION_MAX}),
		.invalid_out(inv_f),
		.region_out(rgn_f),
		.exec_out(exe_f)
	);

	// register decode
	wire logic wr_ctrl = reg_wr_in && (reg_addr_in == REG_CTRL);
	wire logic wr_mask = reg_wr_in && (reg_addr_in == REG_MASK);
	wire logic wr_rgn0 = reg_wr_in && (reg_addr_in == REG_RGN0);
	wire logic wr_rgn1 = reg_wr_in && (reg_addr_in == REG_RGN1);
	wire logic wr_access = reg_wr_in && (reg_addr_in == REG_ACCESS);
	wire logic wr_mode = reg_wr_in && (reg_addr_in == REG_MODE);
	wire logic wr_trace = reg_wr_in && (reg_addr_in == REG_TRACE);
	wire logic wr_unlock = reg_wr_in && (reg_addr_in == REG_UNLOCK);
	wire logic rd_event = reg_rd_in && (reg_addr_in == REG_EVENT);
	wire logic rd_fault = reg_rd_in && (reg_addr_in == REG_FAULT);
	// region and access registers writable only while enabled and unlocked
	wire logic sec_ok = wen_q && !locked_q;
	wire logic in_normal = (mode_q == SSG_MODE_NORMAL);

	// sticky event capture; read clears, a new event wins over the clear
	always_comb
	begin
		event_d = event_q;
		if (rd_event)
			event_d = '0;
		event_d = event_d | det_hit;
	end

	// sticky fault causes; read clears, set wins
	always_comb
	begin
		fault_d = fault_q;
		if (rd_fault)
			fault_d = '0;
		fault_d[FLT_INVALID] = fault_d[FLT_INVALID] | inv_f;
		fault_d[FLT_REGION] = fault_d[FLT_REGION] | rgn_f;
		fault_d[FLT_EXEC] = fault_d[FLT_EXEC] | exe_f;
		fault_d[FLT_DET] = fault_d[FLT_DET] | (any_det && !ctrl_q[CTRL_RST_BIT]);
	end

	always_ff @(posedge core_clk_in)
	begin
		if (!rst_n_in)
		begin
			event_q <= '0;
			fault_q <= '0;
			mask_q <= '0;
		end
		else if (clk_en_in)
		begin
			event_q <= event_d;
			fault_q <= fault_d;
			if (wr_mask)
				mask_q <= reg_wdata_in[NUM_DET-1:0];
		end
	end

	always_ff @(posedge core_clk_in)
	begin
		if (!rst_n_in)
		begin
			wcnt_q <= 8'h00;
			wen_q <= 1'b0;
			locked_q <= 1'b0;
		end
		else if (clk_en_in)
		begin
			if (wcnt_q != WEN_LAST)
				wcnt_q <= wcnt_q + 8'h01;
			if (wr_ctrl && !locked_q && reg_wdata_in[CTRL_WEN_BIT])
				wen_q <= 1'b1;
			if (wcnt_q == WEN_LAST && !wen_q && !(wr_ctrl && reg_wdata_in[CTRL_WEN_BIT]))
				locked_q <= 1'b1;
		end
	end

	// security control registers, only the reaction bit steers detection
	always_ff @(posedge core_clk_in)
	begin
		if (!rst_n_in)
		begin
			ctrl_q <= CTRL_RESET;
			rgn0_q <= ZERO16;
			rgn1_q <= ZERO16;
			access_q <= ACCESS_RESET;
		end
		else if (clk_en_in)
		begin
			if (wr_ctrl && !locked_q)
				ctrl_q <= reg_wdata_in | (16'(wen_q) << CTRL_WEN_BIT);
			if (wr_rgn0 && sec_ok)
				rgn0_q <= reg_wdata_in;
			if (wr_rgn1 && sec_ok)
				rgn1_q <= reg_wdata_in;
			if (wr_access && sec_ok)
				access_q <= reg_wdata_in;
		end
	end

	// reset request on any detection when reset reaction chosen
	always_ff @(posedge core_clk_in)
	begin
		if (!rst_n_in)
			reset_q <= 1'b0;
		else if (clk_en_in)
			reset_q <= any_det && ctrl_q[CTRL_RST_BIT];
	end

	// mode follows nonvolatile bit after every reset
	// mode machine: locked test, open test, normal
	always_ff @(posedge core_clk_in)
	begin
		if (!rst_n_in)
		begin
			mode_q <= SSG_MODE_TEST_LOCKED;
			nv_set_q <= 1'b0;
			trace_q <= ZERO16;
		end
		else if (clk_en_in)
		begin
			nv_set_q <= 1'b0;
			case (mode_q)
				SSG_MODE_TEST_LOCKED:
				begin
					if (nv_normal_in)
						mode_q <= SSG_MODE_NORMAL;
					else if (wr_unlock && reg_wdata_in == TEST_PASSWORD)
						mode_q <= SSG_MODE_TEST_OPEN;
				end
				SSG_MODE_TEST_OPEN:
				begin
					if (nv_normal_in)
						mode_q <= SSG_MODE_NORMAL;
					else if (wr_mode && reg_wdata_in == NORMAL_KEY)
					begin
						mode_q <= SSG_MODE_NORMAL;
						nv_set_q <= 1'b1;
					end
					// trace data writable only in open test mode
					else if (wr_trace)
						trace_q <= reg_wdata_in;
				end
				SSG_MODE_NORMAL:
					mode_q <= SSG_MODE_NORMAL;
				default:
					mode_q <= SSG_MODE_NORMAL;
			endcase
		end
	end

	// read mux
	wire logic [DATA_W-1:0] rd_mux =
		(reg_addr_in == REG_EVENT) ? {9'h000, event_q} :
		(reg_addr_in == REG_CTRL) ? {ctrl_q[15:2], wen_q, ctrl_q[0]} :
		(reg_addr_in == REG_MASK) ? {9'h000, mask_q} :
		(reg_addr_in == REG_FAULT) ? {12'h000, fault_q} :
		(reg_addr_in == REG_RGN0) ? rgn0_q :
		(reg_addr_in == REG_RGN1) ? rgn1_q :
		(reg_addr_in == REG_ACCESS) ? access_q :
		(reg_addr_in == REG_MODE) ? {13'h0000, locked_q, 2'(mode_q)} :
		(reg_addr_in == REG_TRACE) ? trace_q : ZERO16;

	always_ff @(posedge core_clk_in)
	begin
		if (!rst_n_in)
			rdata_q <= ZERO16;
		else if (clk_en_in)
			rdata_q <= reg_rd_in ? rd_mux : ZERO16;
	end

	assign reg_rdata_out = rdata_q;
	assign chip_reset_out = reset_q;
	// fast fault is non-maskable; irq carries the maskable detector events
	assign fast_fault_interrupt_out = |fault_q[FLT_EXEC:FLT_INVALID];
	assign irq_out = |(event_q & mask_q);
	assign test_mode_out = (mode_q == SSG_MODE_TEST_OPEN);
	assign nv_normal_set_out = nv_set_q;

	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);

	chk_lock_after_window: assert property (
		clk_en_in && wcnt_q == WEN_LAST && !wen_q && !reg_wr_in |=> locked_q)
		else $error("lock not engaged after window");
	chk_lock_sticky: assert property (
		locked_q |=> locked_q) else $error("lock released");
	chk_locked_no_write: assert property (
		locked_q && clk_en_in |=> $stable(access_q)) else $error("write while locked");
	chk_det_reset: assert property (
		clk_en_in && any_det && ctrl_q[CTRL_RST_BIT] |=> chip_reset_out)
		else $error("no reset on detection");
	chk_flag_no_reset: assert property (
		clk_en_in && any_det && !ctrl_q[CTRL_RST_BIT] |=> !chip_reset_out && fault_q[FLT_DET])
		else $error("flag reaction wrong");
	chk_event_capture: assert property (
		clk_en_in && det_hit[0] |=> event_q[0]) else $error("event lost");
	chk_invalid_fault: assert property (
		clk_en_in && inv_f |=> fast_fault_interrupt_out) else $error("no fault on invalid");
	chk_region_fault: assert property (
		clk_en_in && (rgn_f || exe_f) |=> fast_fault_interrupt_out)
		else $error("no fault on violation");
	chk_normal_oneway: assert property (
		in_normal |=> in_normal) else $error("left normal mode");
	chk_trace_frozen: assert property (
		in_normal |=> $stable(trace_q)) else $error("trace changed");
	chk_priv_bypass: assert property (
		acc_priv_in |-> !rgn_f && !exe_f) else $error("privileged access flagged");

	cov_det_reset: cover property (any_det && ctrl_q[CTRL_RST_BIT]);
	cov_lock: cover property (!locked_q ##1 locked_q);
	cov_to_normal: cover property (nv_set_q);
	cov_fault: cover property (exe_f);
endmodule
`default_nettype wire

// File: dv/ssg_core_model.sv
// partner model: processor side of the access path and the nonvolatile mode cell
// assumes accesses are launched by the testbench on the core clock
`timescale 1ns/1ps
`default_nettype none
module ssg_core_model
(
	input wire logic core_clk_in,
	input wire logic nv_normal_set_in,
	output logic nv_normal_out,
	output logic acc_valid_out,
	output logic [15:0] acc_addr_out,
	output logic [3:0] acc_kind_out
);
	logic nv_cell = 1'b0;
	logic valid_q = 1'b0;
	logic [15:0] addr_q = 16'h5555;
	logic [3:0] kind_q = 4'h5;
	assign nv_normal_out = nv_cell;
	assign acc_valid_out = valid_q;
	assign acc_addr_out = addr_q;
	assign acc_kind_out = kind_q;
	always @(posedge core_clk_in)
	begin
		if (nv_normal_set_in)
			nv_cell <= 1'b1;
	end
	// kind is {write, fetch, eeprom, privileged}; idle lines show inverted values
	task automatic access(input logic [15:0] a, input logic [3:0] k);
		@(posedge core_clk_in);
		valid_q <= 1'b1;
		addr_q <= a;
		kind_q <= k;
		@(posedge core_clk_in);
		valid_q <= 1'b0;
		addr_q <= ~a;
		kind_q <= ~k;
	endtask
endmodule
`default_nettype wire

// File: dv/ssg_supervisor_tb_top.sv
// testbench for the security supervisor: register port tasks and scenarios
// assumes ssg_pkg and ssg_core_model are compiled first
`timescale 1ns/1ps
`default_nettype none
module ssg_supervisor_tb_top;
	import ssg_pkg::*;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic clk_en = 1'b1;
	logic [ADDR_W-1:0] addr = 8'h00;
	logic [DATA_W-1:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [6:0] det = 7'h00;
	logic [1:0] pad = 2'b00;
	wire logic [15:0] rdata;
	wire logic [15:0] a_addr;
	wire logic [3:0] a_k;
	wire logic [1:0] pad_q;
	wire logic a_v, nv, nv_set, chip_rst, ffi, irq, tmode;
	int fails = 0;
	int samples_checked = 0;
	int rst_hits = 0;
	logic [7:0] regs [7] = '{REG_EVENT, REG_CTRL, REG_MASK, REG_FAULT, REG_ACCESS,
		REG_MODE, 8'h30};
	logic [15:0] ac_addr [7] = '{16'h0040, 16'h0010, 16'h0010, 16'h0030, 16'h0030,
		16'h0010, 16'h0030};
	logic [3:0] ac_kind [7] = '{4'h0, 4'h8, 4'h9, 4'h6, 4'h7, 4'h8, 4'h6};
	logic [15:0] ac_exp [7] = '{16'h0001, 16'h0002, 16'h0000, 16'h0004, 16'h0000,
		16'h0000, 16'h0000};

	always #25 core_clk = ~core_clk;
	always @(posedge core_clk)
	begin
		if (chip_rst === 1'b1)
			rst_hits++;
	end

	ssg_supervisor dut (
		.core_clk_in(core_clk), .rst_n_in(rst_n), .clk_en_in(clk_en),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_rdata_out(rdata), .det_freq_in(det[0]), .det_volt_in(det[1]),
		.det_temp_in(det[2]), .det_light_in(det[3]), .det_insul_in(det[4]),
		.det_shield_in(det[5]), .det_glitch_in(det[6]), .pad_rst_in(pad[1]),
		.pad_clk_in(pad[0]), .pad_rst_out(pad_q[1]), .pad_clk_out(pad_q[0]),
		.acc_valid_in(a_v), .acc_addr_in(a_addr), .acc_write_in(a_k[3]),
		.acc_fetch_in(a_k[2]), .acc_eeprom_in(a_k[1]), .acc_priv_in(a_k[0]),
		.nv_normal_in(nv), .nv_normal_set_out(nv_set), .chip_reset_out(chip_rst),
		.fast_fault_interrupt_out(ffi), .irq_out(irq), .test_mode_out(tmode)
	);
	ssg_core_model core (
		.core_clk_in(core_clk), .nv_normal_set_in(nv_set), .nv_normal_out(nv),
		.acc_valid_out(a_v), .acc_addr_out(a_addr), .acc_kind_out(a_k)
	);

	task automatic finish_test;
		$display("compares %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			fails++;
			$display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic do_reset;
		@(posedge core_clk);
		rst_n <= 1'b0;
		cyc(16);
		rst_n <= 1'b1;
	endtask
	task automatic wreg(input logic [7:0] a, input logic [15:0] d);
		@(posedge core_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge core_clk);
		wr <= 1'b0;
		#1;
	endtask
	// reads one register and compares the masked value
	task automatic rchk(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
		@(posedge core_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge core_clk);
		rd <= 1'b0;
		#1;
		check(rdata & m, e);
	endtask
	// detectors are levels; leave time for the input synchronisers to empty
	task automatic pulse_det(input int i);
		@(posedge core_clk);
		det <= 7'(1 << i);
		cyc(6);
		det <= 7'h00;
		cyc(5);
		#1;
	endtask

	initial
	begin
		cyc(20000);
		fails++;
		finish_test;
	end

	initial
	begin
		do_reset;
		foreach (regs[i])
			rchk(regs[i], 16'hFFFF, 16'h0000);
		wreg(REG_CTRL, 16'h0002);
		rchk(REG_CTRL, 16'h0003, 16'h0002);
		for (int i = 0; i < NUM_DET; i++)
		begin
			pulse_det(i);
			rchk(REG_EVENT, 16'hFFFF, 16'(1 << i));
			rchk(REG_FAULT, 16'h0008, 16'h0008);
		end
		check(16'(rst_hits), 16'h0000);
		wreg(REG_MASK, 16'h0004);
		pulse_det(0);
		check(irq, 1'b0);
		rchk(REG_EVENT, 16'hFFFF, 16'h0001);
		pulse_det(2);
		check(irq, 1'b1);
		rchk(REG_EVENT, 16'hFFFF, 16'h0004);
		check(irq, 1'b0);
		@(posedge core_clk);
		pad <= 2'b11;
		@(posedge core_clk);
		pad <= 2'b00;
		cyc(8);
		#1;
		check(pad_q, 2'b00);
		@(posedge core_clk);
		pad <= 2'b11;
		cyc(10);
		#1;
		check(pad_q, 2'b11);
		wreg(REG_RGN0, 16'h001F);
		wreg(REG_RGN1, 16'h003F);
		rchk(REG_RGN1, 16'hFFFF, 16'h003F);
		for (int j = 0; j < 7; j++)
		begin
			if (j == 5)
				wreg(REG_ACCESS, 16'h003F);
			core.access(ac_addr[j], ac_kind[j]);
			cyc(3);
			#1;
			check(ffi, 16'(ac_exp[j] != 0));
			rchk(REG_FAULT, ac_exp[j] == 0 ? 16'h0007 : ac_exp[j] | 16'h0001,
				ac_exp[j]);
			check(ffi, 1'b0);
		end
		wreg(REG_CTRL, 16'h0003);
		pulse_det(6);
		check(16'(rst_hits != 0), 16'h0001);
		do_reset;
		rchk(REG_CTRL, 16'hFFFF, 16'h0000);
		cyc(130);
		wreg(REG_CTRL, 16'h0002);
		wreg(REG_ACCESS, 16'h0007);
		rchk(REG_CTRL, 16'h0003, 16'h0000);
		rchk(REG_ACCESS, 16'hFFFF, 16'h0000);
		pulse_det(5);
		rchk(REG_EVENT, 16'hFFFF, 16'h0020);
		// a frozen block must not see a detector that comes and goes meanwhile
		@(posedge core_clk);
		clk_en <= 1'b0;
		pulse_det(1);
		@(posedge core_clk);
		clk_en <= 1'b1;
		rchk(REG_EVENT, 16'hFFFF, 16'h0000);
		wreg(REG_UNLOCK, 16'h1234);
		check(tmode, 1'b0);
		wreg(REG_UNLOCK, TEST_PASSWORD);
		check(tmode, 1'b1);
		wreg(REG_TRACE, 16'h00C5);
		rchk(REG_TRACE, 16'hFFFF, 16'h00C5);
		wreg(REG_MODE, NORMAL_KEY);
		cyc(2);
		#1;
		check({tmode, nv}, 2'b01);
		rchk(REG_MODE, 16'h0003, 16'h0002);
		wreg(REG_TRACE, 16'hFFFF);
		rchk(REG_TRACE, 16'hFFFF, 16'h00C5);
		wreg(REG_UNLOCK, TEST_PASSWORD);
		check(tmode, 1'b0);
		do_reset;
		wreg(REG_UNLOCK, TEST_PASSWORD);
		check(tmode, 1'b0);
		rchk(REG_MODE, 16'h0003, 16'h0002);
		finish_test;
	end
endmodule
`default_nettype wire
